// File: hdl/ster_defines.svh
/*
  Constants of the status and service-request block: widths, bit
  positions, reset values and the masks of used bits.
  Assumes inclusion by its bare name from every design file.
*/
`ifndef STER_DEFINES_SVH
`define STER_DEFINES_SVH
`define STER_BYTE_W 8
`define STER_INST_W 15
`define STER_DATA_W 16
`define STER_BYTE_TOP 4'h7
`define STER_INST_TOP 4'hE
`define STER_STD_RESET 8'h80
`define STER_INST_RESET 15'h0000
`define STER_ERR_RESET 8'h00
`define STER_EN_BYTE_RESET 8'h00
`define STER_EN_INST_RESET 15'h0000
`define STER_POLL_RESET 8'h00
`define STER_DATA_RESET 16'h0000
`define STER_STD_USED 8'hFB
`define STER_INST_USED 15'h7FFB
`define STER_ERR_USED 8'hF3
`define STER_SP_REQ_SRC 8'h3C
`define STER_STD_DONE 0
`define STER_STD_INQ 1
`define STER_STD_OUTQ 3
`define STER_STD_EXEC 4
`define STER_STD_UNKNOWN 5
`define STER_STD_PANEL 6
`define STER_STD_POWER 7
`define STER_INST_OUT_A 0
`define STER_INST_OUT_B 1
`define STER_INST_UNLOCK 3
`define STER_INST_RANGE 4
`define STER_INST_SYNC_FREQ 5
`define STER_INST_SYNC_OVL 6
`define STER_INST_STORE 7
`define STER_INST_DATA_A 8
`define STER_INST_DATA_B 9
`define STER_INST_DATA_C 10
`define STER_INST_DATA_D 11
`define STER_INST_CAPTURE 12
`define STER_INST_SWEEP_GO 13
`define STER_INST_SWEEP_END 14
`define STER_ERR_REFCLK 0
`define STER_ERR_BATTERY 1
`define STER_ERR_NET 4
`define STER_ERR_FAST 5
`define STER_ERR_USB_DEV 6
`define STER_ERR_USB_HOST 7
`define STER_SP_ERR 2
`define STER_SP_INST 3
`define STER_SP_OUTPUT 4
`define STER_SP_STD 5
`define STER_SP_REQ 6
`endif

// File: hdl/ster_pkg.sv
/*
  Types of the status and service-request block.
  Assumes the constants header is on the include path.
*/
`include "ster_defines.svh"

package ster_pkg;

  typedef enum logic [2:0] {
    STER_OP_READ_STATUS = 3'h0,
    STER_OP_READ_STATUS_BIT = 3'h1,
    STER_OP_READ_ENABLE = 3'h2,
    STER_OP_READ_ENABLE_BIT = 3'h3,
    STER_OP_WRITE_ENABLE = 3'h4,
    STER_OP_WRITE_ENABLE_BIT = 3'h5,
    STER_OP_CLEAR_ALL = 3'h6,
    STER_OP_MARK_DONE = 3'h7
  } ster_op_t;

  typedef enum logic [1:0] {
    STER_SEL_STD = 2'h0,
    STER_SEL_INST = 2'h1,
    STER_SEL_ERR = 2'h2,
    STER_SEL_POLL = 2'h3
  } ster_sel_t;

  typedef struct packed {
    logic valid;
    ster_op_t op;
    ster_sel_t sel;
    logic [3:0] bit_idx;
    logic [`STER_DATA_W-1:0] data;
  } ster_cmd_t;

  typedef struct packed {
    logic valid;
    logic [`STER_DATA_W-1:0] data;
  } ster_rsp_t;

  typedef struct packed {
    logic valid;
    logic [`STER_BYTE_W-1:0] data;
  } ster_poll_t;

  typedef struct packed {
    logic input_queue_overflow;
    logic output_queue_overflow;
    logic execution_error;
    logic command_unknown;
    logic front_panel_action;
    logic out_chan_a_overload;
    logic out_chan_b_overload;
    logic reference_unlock;
    logic input_range_overload;
    logic sync_freq_out_of_range;
    logic sync_filter_overload;
    logic storage_triggered;
    logic data_chan_a_overload;
    logic data_chan_b_overload;
    logic data_chan_c_overload;
    logic data_chan_d_overload;
    logic capture_done;
    logic sweep_started;
    logic sweep_finished;
    logic ref_clock_fault;
    logic battery_fault;
    logic net_protocol_fault;
    logic fast_transfer_abort;
    logic usb_device_fault;
    logic usb_host_fault;
  } ster_events_t;

  typedef struct packed {
    logic [`STER_BYTE_W-1:0] std_stat;
    logic [`STER_INST_W-1:0] inst_stat;
    logic [`STER_BYTE_W-1:0] err_stat;
    logic [`STER_BYTE_W-1:0] std_en;
    logic [`STER_INST_W-1:0] inst_en;
    logic [`STER_BYTE_W-1:0] err_en;
    logic [`STER_BYTE_W-1:0] poll_en;
    logic [`STER_BYTE_W-1:0] poll_status;
    ster_rsp_t rsp;
    ster_poll_t poll;
    logic queue_flush;
  } ster_state_t;

  typedef struct packed {
    logic [`STER_BYTE_W-1:0] prev;
    logic pending;
  } ster_srq_state_t;

endpackage

// File: hdl/ster_srq_gen.sv
/*
  Service-request generator: edge detection on enabled poll bits
  and the pending request cleared by a bus poll.
  Assumes enabled bits and the poll strobe are synchronous to mclk.
*/
`timescale 1ns/1ns
`include "ster_defines.svh"

module ster_srq_gen
  import ster_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`STER_BYTE_W-1:0] enabled_bits,
  input wire logic bus_poll,
  output logic srq_pending
);

  ster_srq_state_t s_r;
  ster_srq_state_t s_nxt;
  logic rise;

  assign rise = |(enabled_bits & ~s_r.prev);

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = enabled_bits;
    // New request outranks a poll in the same cycle
    s_nxt.pending = rise | (s_r.pending & ~bus_poll);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r.prev <= `STER_POLL_RESET;
      s_r.pending <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign srq_pending = s_r.pending;

endmodule

// File: hdl/ster_top.sv
/*
  Status and service-request core: three sticky status registers
  with enables, the poll summary byte and the request line.
  Assumes a parser that hands over at most one command per cycle
  and event inputs synchronous to mclk; events may be pulses or
  levels, a level simply keeps its bit set.
*/
`timescale 1ns/1ns
`include "ster_defines.svh"

module ster_top
  import ster_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire ster_cmd_t cmd,
  input wire ster_events_t events,
  input wire logic output_pending,
  input wire logic bus_poll,
  output ster_rsp_t rsp,
  output ster_poll_t poll_rsp,
  output logic [`STER_BYTE_W-1:0] poll_status,
  output logic service_request,
  output logic queue_flush
);

  ster_state_t s_r;
  ster_state_t s_nxt;

  logic [`STER_BYTE_W-1:0] std_set;
  logic [`STER_BYTE_W-1:0] std_clr;
  logic [`STER_INST_W-1:0] inst_set;
  logic [`STER_INST_W-1:0] inst_clr;
  logic [`STER_BYTE_W-1:0] err_set;
  logic [`STER_BYTE_W-1:0] err_clr;
  logic [`STER_DATA_W-1:0] clr_mask;
  logic [`STER_DATA_W-1:0] sel_stat;
  logic [`STER_DATA_W-1:0] sel_en;
  logic [`STER_DATA_W-1:0] en_bit_new;
  logic [`STER_BYTE_W-1:0] sp_now;
  logic [`STER_BYTE_W-1:0] sp_req;
  logic cmd_rd_stat;
  logic cmd_rd_stat_bit;
  logic cmd_rd_en;
  logic cmd_rd_en_bit;
  logic cmd_wr_en;
  logic cmd_wr_en_bit;
  logic cmd_clear_all;
  logic cmd_mark_done;
  logic bit_ok;
  logic sum_err;
  logic sum_inst;
  logic sum_std;
  logic srq_query;
  logic srq_pending;

  function automatic logic [`STER_DATA_W-1:0] ster_bit_mask(
    input logic [3:0] idx
  );
    ster_bit_mask = `STER_DATA_W'(1) << idx;
  endfunction

  function automatic logic ster_any(
    input logic [`STER_DATA_W-1:0] stat,
    input logic [`STER_DATA_W-1:0] en
  );
    ster_any = |(stat & en);
  endfunction

  function automatic logic [3:0] ster_top_bit(
    input ster_sel_t sel
  );
    if (sel == STER_SEL_INST) begin
      ster_top_bit = `STER_INST_TOP;
    end else begin
      ster_top_bit = `STER_BYTE_TOP;
    end
  endfunction

  function automatic logic [`STER_DATA_W-1:0] ster_put_bit(
    input logic [`STER_DATA_W-1:0] old,
    input logic [3:0] idx,
    input logic val
  );
    if (val) begin
      ster_put_bit = old | ster_bit_mask(idx);
    end else begin
      ster_put_bit = old & ~ster_bit_mask(idx);
    end
  endfunction

  // Command decode
  assign cmd_rd_stat = cmd.valid && (cmd.op == STER_OP_READ_STATUS);
  assign cmd_rd_stat_bit = cmd.valid && (cmd.op == STER_OP_READ_STATUS_BIT);
  assign cmd_rd_en = cmd.valid && (cmd.op == STER_OP_READ_ENABLE);
  assign cmd_rd_en_bit = cmd.valid && (cmd.op == STER_OP_READ_ENABLE_BIT);
  assign cmd_wr_en = cmd.valid && (cmd.op == STER_OP_WRITE_ENABLE);
  assign cmd_wr_en_bit = cmd.valid && (cmd.op == STER_OP_WRITE_ENABLE_BIT);
  assign cmd_clear_all = cmd.valid && (cmd.op == STER_OP_CLEAR_ALL);
  assign cmd_mark_done = cmd.valid && (cmd.op == STER_OP_MARK_DONE);
  assign bit_ok = cmd.bit_idx <= ster_top_bit(cmd.sel);

  // Summaries from the registered status and enables
  assign sum_err = ster_any({8'h00, s_r.err_stat}, {8'h00, s_r.err_en});
  assign sum_inst = ster_any({1'b0, s_r.inst_stat}, {1'b0, s_r.inst_en});
  assign sum_std = ster_any({8'h00, s_r.std_stat}, {8'h00, s_r.std_en});

  always_comb begin
    sp_now = 8'h00;
    sp_now[`STER_SP_ERR] = sum_err;
    sp_now[`STER_SP_INST] = sum_inst;
    sp_now[`STER_SP_OUTPUT] = output_pending;
    sp_now[`STER_SP_STD] = sum_std;
    sp_req = sp_now & s_r.poll_en & `STER_SP_REQ_SRC;
    srq_query = |sp_req;
    sp_now[`STER_SP_REQ] = srq_query;
  end

  // Standard event sources
  always_comb begin
    std_set = 8'h00;
    std_set[`STER_STD_DONE] = cmd_mark_done;
    std_set[`STER_STD_INQ] = events.input_queue_overflow;
    std_set[`STER_STD_OUTQ] = events.output_queue_overflow;
    std_set[`STER_STD_EXEC] = events.execution_error;
    std_set[`STER_STD_UNKNOWN] = events.command_unknown;
    std_set[`STER_STD_PANEL] = events.front_panel_action;
    std_set = std_set & `STER_STD_USED;
  end

  // Instrument condition sources
  always_comb begin
    inst_set = 15'h0000;
    inst_set[`STER_INST_OUT_A] = events.out_chan_a_overload;
    inst_set[`STER_INST_OUT_B] = events.out_chan_b_overload;
    inst_set[`STER_INST_UNLOCK] = events.reference_unlock;
    inst_set[`STER_INST_RANGE] = events.input_range_overload;
    inst_set[`STER_INST_SYNC_FREQ] = events.sync_freq_out_of_range;
    inst_set[`STER_INST_SYNC_OVL] = events.sync_filter_overload;
    inst_set[`STER_INST_STORE] = events.storage_triggered;
    inst_set[`STER_INST_DATA_A] = events.data_chan_a_overload;
    inst_set[`STER_INST_DATA_B] = events.data_chan_b_overload;
    inst_set[`STER_INST_DATA_C] = events.data_chan_c_overload;
    inst_set[`STER_INST_DATA_D] = events.data_chan_d_overload;
    inst_set[`STER_INST_CAPTURE] = events.capture_done;
    inst_set[`STER_INST_SWEEP_GO] = events.sweep_started;
    inst_set[`STER_INST_SWEEP_END] = events.sweep_finished;
    inst_set = inst_set & `STER_INST_USED;
  end

  // Error sources
  always_comb begin
    err_set = 8'h00;
    err_set[`STER_ERR_REFCLK] = events.ref_clock_fault;
    err_set[`STER_ERR_BATTERY] = events.battery_fault;
    err_set[`STER_ERR_NET] = events.net_protocol_fault;
    err_set[`STER_ERR_FAST] = events.fast_transfer_abort;
    err_set[`STER_ERR_USB_DEV] = events.usb_device_fault;
    err_set[`STER_ERR_USB_HOST] = events.usb_host_fault;
    err_set = err_set & `STER_ERR_USED;
  end

  // Clear masks: whole read, single bit read or clear-all
  always_comb begin
    clr_mask = `STER_DATA_RESET;
    if (cmd_clear_all) begin
      clr_mask = '1;
    end else if (cmd_rd_stat) begin
      clr_mask = '1;
    end else if (cmd_rd_stat_bit && bit_ok) begin
      clr_mask = ster_bit_mask(cmd.bit_idx);
    end
    std_clr = 8'h00;
    inst_clr = 15'h0000;
    err_clr = 8'h00;
    if (cmd_clear_all || (cmd.sel == STER_SEL_STD)) begin
      std_clr = clr_mask[`STER_BYTE_W-1:0];
    end
    if (cmd_clear_all || (cmd.sel == STER_SEL_INST)) begin
      inst_clr = clr_mask[`STER_INST_W-1:0];
    end
    if (cmd_clear_all || (cmd.sel == STER_SEL_ERR)) begin
      err_clr = clr_mask[`STER_BYTE_W-1:0];
    end
  end

  // Register selection for reads and bit writes
  always_comb begin
    sel_stat = `STER_DATA_RESET;
    sel_en = `STER_DATA_RESET;
    if (cmd.sel == STER_SEL_STD) begin
      sel_stat = {8'h00, s_r.std_stat};
      sel_en = {8'h00, s_r.std_en};
    end else if (cmd.sel == STER_SEL_INST) begin
      sel_stat = {1'b0, s_r.inst_stat};
      sel_en = {1'b0, s_r.inst_en};
    end else if (cmd.sel == STER_SEL_ERR) begin
      sel_stat = {8'h00, s_r.err_stat};
      sel_en = {8'h00, s_r.err_en};
    end else begin
      sel_stat = {8'h00, sp_now};
      sel_en = {8'h00, s_r.poll_en};
    end
    en_bit_new = ster_put_bit(sel_en, cmd.bit_idx, cmd.data[0]);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp.valid = 1'b0;
    s_nxt.poll.valid = 1'b0;
    s_nxt.poll_status = sp_now;
    // Sticky status; an event in the clearing cycle survives
    s_nxt.std_stat = (s_r.std_stat & ~std_clr) | std_set;
    s_nxt.inst_stat = (s_r.inst_stat & ~inst_clr) | inst_set;
    s_nxt.err_stat = (s_r.err_stat & ~err_clr) | err_set;
    s_nxt.queue_flush = events.input_queue_overflow | events.output_queue_overflow;
    if (cmd_rd_stat) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.data = sel_stat;
    end else if (cmd_rd_stat_bit) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.data = {15'h0000, bit_ok && ster_any(sel_stat, ster_bit_mask(cmd.bit_idx))};
    end else if (cmd_rd_en) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.data = sel_en;
    end else if (cmd_rd_en_bit) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.data = {15'h0000, bit_ok && ster_any(sel_en, ster_bit_mask(cmd.bit_idx))};
    end else if (cmd_wr_en) begin
      if (cmd.sel == STER_SEL_STD) begin
        s_nxt.std_en = cmd.data[`STER_BYTE_W-1:0];
      end else if (cmd.sel == STER_SEL_INST) begin
        s_nxt.inst_en = cmd.data[`STER_INST_W-1:0];
      end else if (cmd.sel == STER_SEL_ERR) begin
        s_nxt.err_en = cmd.data[`STER_BYTE_W-1:0];
      end else begin
        s_nxt.poll_en = cmd.data[`STER_BYTE_W-1:0];
      end
    end else if (cmd_wr_en_bit && bit_ok) begin
      if (cmd.sel == STER_SEL_STD) begin
        s_nxt.std_en = en_bit_new[`STER_BYTE_W-1:0];
      end else if (cmd.sel == STER_SEL_INST) begin
        s_nxt.inst_en = en_bit_new[`STER_INST_W-1:0];
      end else if (cmd.sel == STER_SEL_ERR) begin
        s_nxt.err_en = en_bit_new[`STER_BYTE_W-1:0];
      end else begin
        s_nxt.poll_en = en_bit_new[`STER_BYTE_W-1:0];
      end
    end
    // Bus poll: summaries as they stand, bit 6 is the pending request
    if (bus_poll) begin
      s_nxt.poll.valid = 1'b1;
      s_nxt.poll.data = sp_now;
      s_nxt.poll.data[`STER_SP_REQ] = srq_pending;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r.std_stat <= `STER_STD_RESET;
      s_r.inst_stat <= `STER_INST_RESET;
      s_r.err_stat <= `STER_ERR_RESET;
      s_r.std_en <= `STER_EN_BYTE_RESET;
      s_r.inst_en <= `STER_EN_INST_RESET;
      s_r.err_en <= `STER_EN_BYTE_RESET;
      s_r.poll_en <= `STER_POLL_RESET;
      s_r.poll_status <= `STER_POLL_RESET;
      s_r.rsp.valid <= 1'b0;
      s_r.rsp.data <= `STER_DATA_RESET;
      s_r.poll.valid <= 1'b0;
      s_r.poll.data <= `STER_POLL_RESET;
      s_r.queue_flush <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ster_srq_gen u_srq (
    .mclk(mclk),
    .rst(rst),
    .enabled_bits(sp_req),
    .bus_poll(bus_poll),
    .srq_pending(srq_pending)
  );

  assign rsp = s_r.rsp;
  assign poll_rsp = s_r.poll;
  assign poll_status = s_r.poll_status;
  assign service_request = srq_pending;
  assign queue_flush = s_r.queue_flush;

endmodule

// File: test/ster_chk.sv
/*
  Port assertions for the status and service-request core.
  Assumes a bind onto ster_top and a single mclk domain.
*/
`timescale 1ns/1ns
`include "ster_defines.svh"

module ster_chk
  import ster_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire ster_cmd_t cmd,
  input wire ster_events_t events,
  input wire logic output_pending,
  input wire logic bus_poll,
  input wire ster_rsp_t rsp,
  input wire ster_poll_t poll_rsp,
  input wire logic [`STER_BYTE_W-1:0] poll_status,
  input wire logic service_request,
  input wire logic queue_flush
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Either queue overflow seen this cycle
  logic overflow_in;
  assign overflow_in = events.input_queue_overflow || events.output_queue_overflow;

  sequence s_read_taken;
    cmd.valid && cmd.op inside {STER_OP_READ_STATUS, STER_OP_READ_STATUS_BIT, STER_OP_READ_ENABLE,
      STER_OP_READ_ENABLE_BIT};
  endsequence
  sequence s_quiet_clear;
    cmd.valid && cmd.op == STER_OP_CLEAR_ALL && events == '0;
  endsequence
  sequence s_poll_with_req;
    bus_poll && service_request;
  endsequence

  a_unused_bits_zero: assert property (poll_status[1:0] == 2'h0 && !poll_status[7])
    else $error("unused poll bits set");
  a_pending_shown: assert property (output_pending [*3] |-> poll_status[4])
    else $error("pending output not shown");
  a_pending_gone: assert property (!output_pending [*3] |-> !poll_status[4])
    else $error("pending bit without output");
  a_req_from_view: assert property ($rose(service_request) |-> poll_status[6])
    else $error("request without enabled bit");
  a_req_stands: assert property (service_request && !bus_poll |=> service_request)
    else $error("request dropped without poll");
  a_poll_first: assert property (s_poll_with_req |=> poll_rsp.valid && poll_rsp.data[6])
    else $error("first poll lost request bit");
  a_poll_later: assert property (bus_poll && !service_request |=> poll_rsp.valid && !poll_rsp.data[6])
    else $error("later poll shows request bit");
  a_poll_answer_cause: assert property (poll_rsp.valid |-> $past(bus_poll))
    else $error("poll answer without poll");
  a_flush_cause: assert property (overflow_in |=> queue_flush)
    else $error("overflow without flush");
  a_flush_only: assert property (queue_flush |-> $past(overflow_in))
    else $error("flush without overflow");
  a_read_answer: assert property (s_read_taken |=> rsp.valid)
    else $error("read gave no answer");
  a_clear_all_sums: assert property (s_quiet_clear |=> ##1 (poll_status[3:2] == 2'h0 && !poll_status[5]))
    else $error("summary left after clear-all");
endmodule

bind ster_top ster_chk u_chk (.mclk(mclk), .rst(rst), .cmd(cmd), .events(events), .output_pending(output_pending),
  .bus_poll(bus_poll), .rsp(rsp), .poll_rsp(poll_rsp), .poll_status(poll_status),
  .service_request(service_request), .queue_flush(queue_flush));

// File: test/ster_ctrl_model.sv
/*
  Bus controller model: answers a service request with a serial poll,
  promptly or after lag cycles, and polls on demand.
  Assumes mclk of the core; drives bus_poll at the falling edge.
*/
`timescale 1ns/1ns
`include "ster_defines.svh"

module ster_ctrl_model
  import ster_pkg::*;
(
  input wire logic mclk,
  input wire logic service_request,
  input wire ster_poll_t poll_rsp,
  input wire logic auto_en,
  input wire logic poll_go,
  input wire logic [3:0] lag,
  output logic bus_poll,
  output logic [`STER_BYTE_W-1:0] last_poll,
  output logic [7:0] n_polls
);
  logic want = 1'b0;
  logic [3:0] cnt = 4'h0;

  initial begin
    bus_poll = 1'b0;
    last_poll = 8'h00;
    n_polls = 8'h00;
  end

  // Poll after a request is seen, then keep the answer
  always @(posedge mclk) begin
    want <= poll_go;
    if (auto_en && service_request && !bus_poll) begin
      if (cnt == lag) begin
        want <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      cnt <= 4'h0;
    end
    if (poll_rsp.valid) begin
      last_poll <= poll_rsp.data;
      n_polls <= n_polls + 8'h01;
    end
  end

  always @(negedge mclk) begin
    bus_poll <= want;
  end
endmodule

// File: test/tb.sv
/*
  Self-checking bench for ster_top with the bus controller model.
  Assumes the checker is bound through its own file.
*/
`timescale 1ns/1ns

module tb
  import ster_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  ster_cmd_t cmd = '0;
  ster_events_t events = '0;
  logic output_pending = 1'b0;
  logic auto_en = 1'b0;
  logic poll_go = 1'b0;
  logic [3:0] lag = 4'h0;
  logic bus_poll, service_request, queue_flush;
  ster_rsp_t rsp;
  ster_poll_t poll_rsp;
  logic [7:0] poll_status, last_poll, n_polls;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam int BIT_OF [25] = '{7, 6, 5, 4, 1, 0, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 1, 0, 6, 5, 4, 3, 1};

  always #2 mclk = ~mclk;

  ster_top u_dut (.mclk(mclk), .rst(rst), .cmd(cmd), .events(events), .output_pending(output_pending),
    .bus_poll(bus_poll), .rsp(rsp), .poll_rsp(poll_rsp), .poll_status(poll_status),
    .service_request(service_request), .queue_flush(queue_flush));
  ster_ctrl_model u_ctrl (.mclk(mclk), .service_request(service_request), .poll_rsp(poll_rsp),
    .auto_en(auto_en), .poll_go(poll_go), .lag(lag), .bus_poll(bus_poll), .last_poll(last_poll),
    .n_polls(n_polls));

  task automatic bad(input logic [15:0] got, input logic [15:0] exp);
    n_mismatch++;
    $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) bad(got, exp);
  endtask
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) bad({8'h00, got}, {8'h00, exp});
  endtask
  task automatic chk_f(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) bad({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Valid drops for one edge between commands
  task automatic op(input ster_op_t o, input ster_sel_t s, input logic [3:0] i, input logic [15:0] d);
    cmd = '{1'b1, o, s, i, d};
    tick(1);
    cmd.valid = 1'b0;
    tick(1);
  endtask
  task automatic query(input ster_op_t o, input ster_sel_t s, input logic [3:0] i, input logic [15:0] exp);
    cmd = '{1'b1, o, s, i, 16'h0000};
    tick(1);
    cmd.valid = 1'b0;
    chk_f(rsp.valid, 1'b1);
    chk_w(rsp.data, exp);
    tick(1);
  endtask
  task automatic pulse(input logic [24:0] m);
    events = m;
    tick(1);
    events = '0;
  endtask
  task automatic wait_poll(input logic [7:0] n);
    int t;
    t = 0;
    while (n_polls !== n && t < 30) begin
      tick(1);
      t++;
    end
    chk_b(n_polls, n);
  endtask
  function automatic ster_sel_t sel_of(input int k);
    return (k < 6) ? STER_SEL_ERR : (k < 20) ? STER_SEL_INST : STER_SEL_STD;
  endfunction

  task automatic t_power_on;
    query(STER_OP_READ_STATUS, STER_SEL_STD, 4'h0, 16'h0080);
    query(STER_OP_READ_STATUS, STER_SEL_STD, 4'h0, 16'h0000);
    query(STER_OP_READ_STATUS_BIT, STER_SEL_STD, 4'h9, 16'h0000);
  endtask

  task automatic t_event_map;
    for (int k = 0; k < 25; k++) begin
      pulse(25'h0000001 << k);
      chk_f(queue_flush, k > 22);
      tick(3);
      query(STER_OP_READ_STATUS, sel_of(k), 4'h0, 16'h0001 << BIT_OF[k]);
      query(STER_OP_READ_STATUS, sel_of(k), 4'h0, 16'h0000);
    end
    op(STER_OP_MARK_DONE, STER_SEL_STD, 4'h0, 16'h0000);
    query(STER_OP_READ_STATUS, STER_SEL_STD, 4'h0, 16'h0001);
    pulse(25'h0600000);
    query(STER_OP_READ_STATUS_BIT, STER_SEL_STD, 4'h4, 16'h0001);
    query(STER_OP_READ_STATUS, STER_SEL_STD, 4'h0, 16'h0020);
  endtask

  task automatic t_request;
    op(STER_OP_WRITE_ENABLE, STER_SEL_INST, 4'h0, 16'h0008);
    op(STER_OP_WRITE_ENABLE_BIT, STER_SEL_POLL, 4'h3, 16'h0001);
    pulse(25'h0020000);
    tick(1);
    chk_f(service_request, 1'b1);
    chk_b(poll_status, 8'h48);
    query(STER_OP_READ_STATUS, STER_SEL_POLL, 4'h0, 16'h0048);
    query(STER_OP_READ_STATUS_BIT, STER_SEL_POLL, 4'h6, 16'h0001);
    chk_f(service_request, 1'b1);
    lag = 4'h3;
    auto_en = 1'b1;
    wait_poll(8'h01);
    chk_b(last_poll, 8'h48);
    chk_f(service_request, 1'b0);
    chk_b(poll_status, 8'h48);
    poll_go = 1'b1;
    tick(1);
    poll_go = 1'b0;
    wait_poll(8'h02);
    chk_b(last_poll, 8'h08);
    pulse(25'h0020000);
    tick(3);
    chk_f(service_request, 1'b0);
    query(STER_OP_READ_STATUS, STER_SEL_INST, 4'h0, 16'h0008);
    tick(1);
    chk_b(poll_status, 8'h00);
    pulse(25'h0020000);
    wait_poll(8'h03);
    query(STER_OP_READ_STATUS, STER_SEL_INST, 4'h0, 16'h0008);
  endtask

  task automatic t_summary;
    lag = 4'h0;
    op(STER_OP_WRITE_ENABLE, STER_SEL_STD, 4'h0, 16'h0030);
    op(STER_OP_WRITE_ENABLE, STER_SEL_POLL, 4'h0, 16'h0020);
    pulse(25'h0600000);
    tick(4);
    wait_poll(8'h04);
    chk_b(last_poll, 8'h60);
    query(STER_OP_READ_STATUS_BIT, STER_SEL_STD, 4'h4, 16'h0001);
    tick(1);
    chk_b(poll_status, 8'h60);
    pulse(25'h0400000);
    tick(3);
    chk_f(service_request, 1'b0);
    query(STER_OP_READ_STATUS, STER_SEL_STD, 4'h0, 16'h0030);
    tick(1);
    chk_b(poll_status, 8'h00);
    pulse(25'h0400000);
    wait_poll(8'h05);
    op(STER_OP_WRITE_ENABLE_BIT, STER_SEL_STD, 4'h4, 16'h0000);
    tick(1);
    chk_b(poll_status, 8'h00);
    pulse(25'h0000401);
    op(STER_OP_CLEAR_ALL, STER_SEL_STD, 4'h0, 16'h0000);
    query(STER_OP_READ_ENABLE, STER_SEL_STD, 4'h0, 16'h0020);
    query(STER_OP_READ_ENABLE_BIT, STER_SEL_STD, 4'h5, 16'h0001);
    query(STER_OP_READ_ENABLE, STER_SEL_INST, 4'h0, 16'h0008);
    query(STER_OP_READ_STATUS, STER_SEL_STD, 4'h0, 16'h0000);
    query(STER_OP_READ_STATUS, STER_SEL_INST, 4'h0, 16'h0000);
    query(STER_OP_READ_STATUS, STER_SEL_ERR, 4'h0, 16'h0000);
    output_pending = 1'b1;
    tick(3);
    chk_b(poll_status, 8'h10);
    output_pending = 1'b0;
    tick(3);
    chk_b(poll_status, 8'h00);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles of the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    tick(20);
    rst = 1'b0;
    tick(2);
    t_power_on;
    t_event_map;
    t_request;
    t_summary;
    finish_test;
  end
endmodule
